// ==== dv/tsc_host_model.sv ====
// Host model, master of the serial link
`timescale 1ns/10ps

module tsc_host_model (
  input  wire clk,
  input  wire sdo,
  output reg  chip_select_low,
  output reg  sclk,
  output reg  sdi
);
  integer fall_n;

  // Link idle: select high, clock parked low
  initial begin
    chip_select_low = 1'b1;
    sclk = 1'b0;
    sdi = 1'b1;
    fall_n = 0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One frame, 4 clk per serial phase
  // thirty-two clocks
  task xfer(input [15:0] cmd, output [11:0] res);
    integer i;
    begin
      res = 12'h000;
      fall_n = 0;
      @(negedge clk);
      chip_select_low = 1'b0;
      for (i = 0; i < 32; i = i + 1) begin
        // bit changes after the fall, zeros after command
        sdi = (i < 16) ? cmd[15 - i] : 1'b0;
        repeat (2) @(negedge clk);
        // Result bit taken before the device moves on
        if (i > 20)
          res = {res[10:0], sdo};
        repeat (2) @(negedge clk);
        sclk = 1'b1;
        repeat (4) @(negedge clk);
        sclk = 1'b0;
        fall_n = i + 1;
      end
      repeat (2) @(negedge clk);
      res = {res[10:0], sdo};
      // Released data line shows no stale level
      sdi = ~sdi;
      chip_select_low = 1'b1;
      repeat (6) @(negedge clk);
    end
  endtask
endmodule // tsc_host_model

// ==== dv/tsc_seq_asserts.sv ====
// Port checker for the touch command sequencer
`timescale 1ns/10ps

module tsc_seq_asserts (
  input wire clk,
  input wire nrst,
  input wire chip_select_low,
  input wire pen_sense_low,
  input wire touch_block_off,
  input wire sdo_oe,
  input wire busy,
  input wire busy_oe,
  input wire pen_touch_irq_low,
  input wire x_plus_plate,
  input wire x_minus_plate,
  input wire y_plus_plate,
  input wire y_minus_plate,
  input wire adc_power,
  input wire adc_sample,
  input wire axis_select_high,
  input wire axis_select_low,
  input wire power_down_select
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  ////////////////////////////////////////////////////////////////////////////
  // Output drive tied to the frame
  AST_OE_IDLE: assert property (
    chip_select_low [*5] |-> !sdo_oe && !busy_oe)
    else $error("output enable while select high");
  AST_BUSY_FRAME: assert property (
    busy |-> sdo_oe && busy_oe)
    else $error("busy outside a frame");
  AST_CONV_START: assert property (
    $rose(busy) |-> !adc_sample && adc_power && pen_touch_irq_low)
    else $error("conversion start state wrong");

  ////////////////////////////////////////////////////////////////////////////
  // Idle plate and converter state
  AST_AUTO_OFF: assert property (
    (chip_select_low && !power_down_select && !touch_block_off) [*6]
    |-> y_minus_plate && !x_plus_plate && !x_minus_plate && !y_plus_plate)
    else $error("idle plates wrong");
  AST_ADC_OFF: assert property (
    (chip_select_low && !power_down_select) [*6] |-> !adc_power)
    else $error("converter on while idle");
  AST_BLOCK_OFF: assert property (
    touch_block_off [*3] |-> pen_touch_irq_low && !(x_plus_plate
      || x_minus_plate || y_plus_plate || y_minus_plate))
    else $error("plates on with touch block off");

  ////////////////////////////////////////////////////////////////////////////
  // Pen interrupt and held command
  AST_PEN_MASK: assert property (
    power_down_select && $past(power_down_select) |-> pen_touch_irq_low)
    else $error("pen interrupt low with power-down set");
  AST_PEN_FOLLOW: assert property (
    (chip_select_low && !power_down_select && !touch_block_off
      && $stable(pen_sense_low)) [*6] |-> pen_touch_irq_low == pen_sense_low)
    else $error("pen interrupt not following contact");
  AST_CMD_HOLD: assert property (
    !chip_select_low [*4] |-> $stable({axis_select_high, axis_select_low,
      power_down_select}))
    else $error("stored command changed inside a frame");
endmodule // tsc_seq_asserts

bind tsc_touch_seq tsc_seq_asserts u_chk (
  .clk(clk), .nrst(nrst), .chip_select_low(chip_select_low),
  .pen_sense_low(pen_sense_low), .touch_block_off(touch_block_off),
  .sdo_oe(sdo_oe), .busy(busy), .busy_oe(busy_oe),
  .pen_touch_irq_low(pen_touch_irq_low), .x_plus_plate(x_plus_plate),
  .x_minus_plate(x_minus_plate), .y_plus_plate(y_plus_plate),
  .y_minus_plate(y_minus_plate), .adc_power(adc_power),
  .adc_sample(adc_sample), .axis_select_high(axis_select_high),
  .axis_select_low(axis_select_low), .power_down_select(power_down_select)
);

// ==== dv/tsc_touch_seq_tb_top.sv ====
// Self-checking bench for the touch command sequencer
`timescale 1ns/10ps

module tsc_touch_seq_tb_top;
  reg         clk;
  reg         nrst;
  reg         pen_sense_low;
  reg         adc_cmp;
  reg         touch_block_off;
  reg  [11:0] vin;
  reg  [11:0] res;
  reg  [47:0] vtab;
  wire        csl;
  wire        sclk;
  wire        sdi;
  wire        sdo;
  wire        sdo_oe;
  wire        busy;
  wire        busy_oe;
  wire        irq;
  wire        pwr;
  wire        smp;
  wire        pup;
  wire [1:0]  sns;
  wire [3:0]  plates;
  wire [2:0]  cmd;
  wire [11:0] dac;
  integer     n_mismatch;
  integer     cmp_count;
  integer     k;

  tsc_touch_seq uut (
    .clk(clk), .nrst(nrst), .chip_select_low(csl), .sclk(sclk), .sdi(sdi),
    .pen_sense_low(pen_sense_low), .adc_cmp(adc_cmp),
    .touch_block_off(touch_block_off), .sdo(sdo), .sdo_oe(sdo_oe),
    .busy(busy), .busy_oe(busy_oe), .pen_touch_irq_low(irq),
    .x_plus_plate(plates[3]), .x_minus_plate(plates[2]),
    .y_plus_plate(plates[1]), .y_minus_plate(plates[0]),
    .pen_pullup_en(pup), .adc_power(pwr), .adc_sample(smp),
    .adc_sense_sel(sns), .adc_dac(dac), .axis_select_high(cmd[2]),
    .axis_select_low(cmd[1]), .power_down_select(cmd[0])
  );

  tsc_host_model host (
    .clk(clk), .sdo(sdo), .chip_select_low(csl), .sclk(sclk), .sdi(sdi)
  );

  // Clock and comparator of the analog input
  always #10 clk = ~clk;
  always @(negedge clk) adc_cmp <= (vin >= dac);

  ////////////////////////////////////////////////////////////////////////////
  // Compare, count and report
  task chk(input [63:0] nm, input [11:0] exp, input [11:0] got);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("unexpected %0s exp %h got %h", nm, exp, got);
      end
    end
  endtask

  task test_done;
    begin
      $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  // Plates and sensed input for each channel code
  function [3:0] pl_exp(input [1:0] a);
    pl_exp = (a == 2'h0) ? 4'hC : (a == 2'h1) ? 4'h3 : 4'h6;
  endfunction
  function [1:0] sn_exp(input [1:0] a);
    sn_exp = (a == 2'h0) ? 2'h0 : (a == 2'h3) ? 2'h2 : 2'h1;
  endfunction

  // Touch frame with checks inside it; lng: long sampling expected
  task touch(input [1:0] a, input pds, input lng, input [11:0] v);
    begin
      vin = v;
      fork
        host.xfer({1'b1, a, pds, 12'h000}, res);
        begin
          wait (host.fall_n == 2);
          repeat (2) @(negedge clk);
          chk("sample", lng, smp);
          wait (host.fall_n == 10);
          repeat (2) @(negedge clk);
          chk("plates", pl_exp(a), plates);
          chk("sense", sn_exp(a), sns);
          chk("busy", 12'h1, busy);
          chk("irq", 12'h1, irq);
          chk("power", 12'h1, pwr);
        end
      join
      chk("result", v, res);
      chk("cmd", {a, pds}, cmd);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    pen_sense_low = 1'b1;
    touch_block_off = 1'b0;
    vin = 12'h000;
    vtab = {12'hFFF, 12'h001, 12'h800, 12'h7FF};
    n_mismatch = 0;
    cmp_count = 0;
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    chk("cmd", 12'h0, cmd);
    chk("plates", 12'h1, plates);
    chk("oe", 12'h0, {sdo_oe, busy_oe});
    chk("irq", 12'h1, irq);
    chk("pullup", 12'h1, pup);
    pen_sense_low = 1'b0;
    repeat (6) @(negedge clk);
    chk("irq", 12'h0, irq);
    for (k = 0; k < 4; k = k + 1) begin
      touch(k[1:0], 1'b0, 1'b0, vtab[k*12 +: 12]);
      chk("plates", 12'h1, plates);
      chk("power", 12'h0, pwr);
      chk("irq", 12'h0, irq);
      chk("oe", 12'h0, {sdo_oe, busy_oe});
    end
    touch(2'h3, 1'b1, 1'b0, 12'h5A3);
    chk("plates", 12'h6, plates);
    chk("irq", 12'h1, irq);
    chk("pullup", 12'h0, pup);
    touch(2'h3, 1'b1, 1'b1, 12'h3C4);
    host.xfer(16'h0080, res);
    chk("cmd", 12'h7, cmd);
    chk("irq", 12'h1, irq);
    touch(2'h0, 1'b0, 1'b0, 12'hA5A);
    repeat (4) @(negedge clk);
    chk("irq", 12'h0, irq);
    touch_block_off = 1'b1;
    repeat (6) @(negedge clk);
    chk("plates", 12'h0, plates);
    chk("irq", 12'h1, irq);
    chk("pullup", 12'h0, pup);
    touch_block_off = 1'b0;
    repeat (6) @(negedge clk);
    chk("plates", 12'h1, plates);
    test_done;
  end

  // Watchdog, about four and a half times the expected run
  initial begin
    #200000;
    n_mismatch = n_mismatch + 1;
    test_done;
  end
endmodule // tsc_touch_seq_tb_top

// ==== hw/tsc_defs.vh ====
// Constants for the touch command sequencer
`ifndef TSC_DEFS_VH
`define TSC_DEFS_VH

// Serial clock edge counter
`define TSC_CNT_W        6
`define TSC_CNT_MAX      6'h3F

// Rising edges carrying the command fields (bit 15, 14, 13, 12)
`define TSC_START_EDGE   6'h01
`define TSC_AXIS_HI_EDGE 6'h02
`define TSC_AXIS_LO_EDGE 6'h03
`define TSC_PD_EDGE      6'h04

// Falling edge counts framing sampling, conversion and busy
`define TSC_SAMPLE_EDGE  6'h03
`define TSC_CONV_EDGE    6'h06
`define TSC_SAR_FIRST    6'h07
`define TSC_SAR_LAST     6'h12
`define TSC_BUSY_END     6'h14

// Rising edge of the first result bit, and last shifting fall
`define TSC_OUT_EDGE     6'h15
`define TSC_XFER_EDGES   6'h20

// Result width and first trial code
`define TSC_RES_W        12
`define TSC_SAR_INIT     12'h800

// Channel field codes
`define TSC_AXIS_X       2'h0
`define TSC_AXIS_Y       2'h1
`define TSC_AXIS_Z1      2'h2
`define TSC_AXIS_Z2      2'h3

// Converter sense input select
`define TSC_SENSE_YP     2'h0
`define TSC_SENSE_XP     2'h1
`define TSC_SENSE_YN     2'h2

// Reset values of the stored touch command
`define TSC_AXIS_RST     2'h0
`define TSC_PD_RST       1'h0

`endif

// ==== hw/tsc_sar.v ====
// Successive approximation register for the 12-bit conversion
`timescale 1ns/10ps
`include "tsc_defs.vh"

module tsc_sar #(
  parameter W = `TSC_RES_W
) (
  input  wire         clk,
  input  wire         nrst,
  input  wire         start,
  input  wire         step,
  input  wire         cmp,
  output reg  [W-1:0] trial
);

  reg [W-1:0] mask;

  // Load mid code on start, decide one bit per step
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      trial <= {W{1'b0}};
      mask  <= {W{1'b0}};
    end else if (start) begin
      trial <= `TSC_SAR_INIT;
      mask  <= `TSC_SAR_INIT;
    end else if (step && (mask != {W{1'b0}})) begin
      trial <= (cmp ? trial : (trial & ~mask)) | (mask >> 1);
      mask  <= mask >> 1;
    end
  end

endmodule // tsc_sar

// ==== hw/tsc_sync.v ====
// Two-stage synchroniser for inputs from outside the clock domain
`timescale 1ns/10ps

module tsc_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         nrst,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);

  reg [W-1:0] meta;

  // First stage is read by the second stage only
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta <= {W{1'b0}};
      q    <= {W{1'b0}};
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule // tsc_sync

// ==== hw/tsc_touch_seq.v ====
// Touch screen command sequencer, serial side and plate control
`timescale 1ns/10ps
`include "tsc_defs.vh"

module tsc_touch_seq #(
  parameter RES_W = `TSC_RES_W
) (
  input  wire             clk,
  input  wire             nrst,
  input  wire             chip_select_low,
  input  wire             sclk,
  input  wire             sdi,
  input  wire             pen_sense_low,
  input  wire             adc_cmp,
  input  wire             touch_block_off,
  output reg              sdo,
  output wire             sdo_oe,
  output reg              busy,
  output wire             busy_oe,
  output reg              pen_touch_irq_low,
  output reg              x_plus_plate,
  output reg              x_minus_plate,
  output reg              y_plus_plate,
  output reg              y_minus_plate,
  output reg              pen_pullup_en,
  output reg              adc_power,
  output reg              adc_sample,
  output reg  [1:0]       adc_sense_sel,
  output wire [RES_W-1:0] adc_dac,
  output wire             axis_select_high,
  output wire             axis_select_low,
  output wire             power_down_select
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  wire [4:0]              sync_q;
  wire                    cs_s;
  wire                    sclk_s;
  wire                    sdi_s;
  wire                    pen_s;
  wire                    cmp_s;
  reg                     sclk_q;
  reg                     cs_q;
  wire                    cs_act;
  wire                    sclk_rise;
  wire                    sclk_fall;
  wire                    cs_rise;
  reg  [`TSC_CNT_W-1:0]   rise_cnt;
  reg  [`TSC_CNT_W-1:0]   fall_cnt;
  reg                     touch_txn;
  reg  [1:0]              cmd_axis;
  reg                     cmd_pd;
  reg  [1:0]              held_axis;
  reg                     held_pd;
  wire                    axis_known;
  wire                    pd_known;
  wire [1:0]              eff_axis;
  wire                    eff_pd;
  wire                    same_axis;
  wire                    win_long;
  wire                    win_short;
  wire                    conv_phase;
  wire                    sar_start;
  wire                    sar_step;
  reg  [RES_W-1:0]        out_sh;
  reg                     next_adc_power;
  reg                     next_adc_sample;
  reg                     next_busy;
  reg                     next_irq;
  reg                     next_pullup;
  reg                     drv_on;
  reg  [3:0]              next_plates;
  reg  [1:0]              next_sense;

  // True when this edge is the n-th since select fell
  function nth;
    input [`TSC_CNT_W-1:0] cnt;
    input [`TSC_CNT_W-1:0] n;
    begin
      nth = ((cnt + 6'h01) == n);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection
  // Select and pen enter inverted, so cleared flops read as idle
  tsc_sync #(
    .W    (5)
  ) u_sync (
    .clk  (clk),
    .nrst (nrst),
    .d    ({~chip_select_low, sclk, sdi, ~pen_sense_low, adc_cmp}),
    .q    (sync_q)
  );

  // Synchronised pins; select high and no pen read as idle after reset
  assign cs_s   = ~sync_q[4];
  assign sclk_s = sync_q[3];
  assign sdi_s  = sync_q[2];
  assign pen_s  = ~sync_q[1];
  assign cmp_s  = sync_q[0];

  // Delayed copies for edge detection
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sclk_q <= 1'h0;
      cs_q   <= 1'h1;
    end else begin
      sclk_q <= sclk_s;
      cs_q   <= cs_s;
    end
  end

  assign cs_act    = ~cs_s & ~cs_q;
  assign sclk_rise = sclk_s & ~sclk_q & cs_act;
  assign sclk_fall = ~sclk_s & sclk_q & cs_act;
  assign cs_rise   = cs_s & ~cs_q;

  ////////////////////////////////////////////////////////////////////////////
  // Serial clock edge counters
  // edge counting
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rise_cnt <= 6'h00;
      fall_cnt <= 6'h00;
    end else if (!cs_act) begin
      rise_cnt <= 6'h00;
      fall_cnt <= 6'h00;
    end else begin
      if (sclk_rise && (rise_cnt != `TSC_CNT_MAX))
        rise_cnt <= rise_cnt + 6'h01;
      if (sclk_fall && (fall_cnt != `TSC_CNT_MAX))
        fall_cnt <= fall_cnt + 6'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command capture and stored touch command
  // rising edge capture
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      touch_txn <= 1'h0;
      cmd_axis  <= `TSC_AXIS_RST;
      cmd_pd    <= `TSC_PD_RST;
    end else if (!cs_act) begin
      touch_txn <= 1'h0;
    end else if (sclk_rise) begin
      if (nth(rise_cnt, `TSC_START_EDGE))
        touch_txn <= sdi_s;
      if (nth(rise_cnt, `TSC_AXIS_HI_EDGE))
        cmd_axis[1] <= sdi_s;
      if (nth(rise_cnt, `TSC_AXIS_LO_EDGE))
        cmd_axis[0] <= sdi_s;
      if (nth(rise_cnt, `TSC_PD_EDGE))
        cmd_pd <= sdi_s;
    end
  end

  // only touch commands replace it, at select rise
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      held_axis <= `TSC_AXIS_RST;
      held_pd   <= `TSC_PD_RST;
    end else if (cs_rise && touch_txn &&
                 (rise_cnt >= `TSC_PD_EDGE)) begin
      held_axis <= cmd_axis;
      held_pd   <= cmd_pd;
    end
  end

  assign axis_select_high  = held_axis[1];
  assign axis_select_low   = held_axis[0];
  assign power_down_select = held_pd;

  // New fields take effect once fully received
  assign axis_known = touch_txn & (rise_cnt >= `TSC_AXIS_LO_EDGE);
  assign pd_known   = touch_txn & (rise_cnt >= `TSC_PD_EDGE);
  assign eff_axis   = axis_known ? cmd_axis : held_axis;
  assign eff_pd     = pd_known ? cmd_pd : held_pd;
  // long window dropped once a received axis bit differs
  assign same_axis  = ((rise_cnt < `TSC_AXIS_HI_EDGE) |
                       (cmd_axis[1] == held_axis[1])) &
                      ((rise_cnt < `TSC_AXIS_LO_EDGE) |
                       (cmd_axis[0] == held_axis[0]));

  ////////////////////////////////////////////////////////////////////////////
  // Sampling windows and converter power
  // long window from select fall
  assign win_long  = cs_act & held_pd & same_axis &
                     (fall_cnt < `TSC_CONV_EDGE) &
                     (touch_txn | (rise_cnt == 6'h00));
  // short window, third to sixth fall
  assign win_short = cs_act & touch_txn &
                     (fall_cnt >= `TSC_SAMPLE_EDGE) &
                     (fall_cnt < `TSC_CONV_EDGE);
  assign conv_phase = cs_act & touch_txn &
                      (fall_cnt >= `TSC_CONV_EDGE);

  // Power, sample and busy next values
  always @* begin
    next_adc_power  = 1'h0;
    next_adc_sample = 1'h0;
    if (!touch_block_off) begin
      // power only while select is low
      next_adc_power  = cs_act &
                        (win_long | (touch_txn &
                        (fall_cnt >= `TSC_SAMPLE_EDGE)));
      next_adc_sample = win_long | win_short;
    end
    next_busy = conv_phase & (fall_cnt < `TSC_BUSY_END);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Plate drivers and sense select
  // Driver switch pattern from power state and axis
  always @* begin
    // drivers stay on with power-down one
    drv_on      = held_pd | next_adc_power;
    next_plates = 4'h0;
    next_sense  = `TSC_SENSE_YP;
    if (touch_block_off) begin
      next_plates = 4'h0;
    end else if (!drv_on) begin
      next_plates = 4'h1;
    end else begin
      // channel decode, {x+, x-, y+, y-}
      case (eff_axis)
        `TSC_AXIS_X: begin
          next_plates = 4'hC;
          next_sense  = `TSC_SENSE_YP;
        end
        `TSC_AXIS_Y: begin
          next_plates = 4'h3;
          next_sense  = `TSC_SENSE_XP;
        end
        `TSC_AXIS_Z1: begin
          next_plates = 4'h6;
          next_sense  = `TSC_SENSE_XP;
        end
        `TSC_AXIS_Z2: begin
          next_plates = 4'h6;
          next_sense  = `TSC_SENSE_YN;
        end
        default: next_plates = 4'h1;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pen interrupt
  // Pen output and pull-up next values
  always @* begin
    next_irq    = 1'h1;
    next_pullup = 1'h0;
    if (touch_block_off || eff_pd || held_pd) begin
      // disabled until power-down zero is held
      next_irq = 1'h1;
    end else if (conv_phase) begin
      next_irq = 1'h1;
    end else begin
      next_irq    = pen_s;
      next_pullup = ~drv_on;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered control outputs
  // Flops for the analog control and status outputs except adc_dac
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      adc_power         <= 1'h0;
      adc_sample        <= 1'h0;
      busy              <= 1'h0;
      pen_touch_irq_low <= 1'h1;
      pen_pullup_en     <= 1'h0;
      x_plus_plate      <= 1'h0;
      x_minus_plate     <= 1'h0;
      y_plus_plate      <= 1'h0;
      y_minus_plate     <= 1'h0;
      adc_sense_sel     <= `TSC_SENSE_YP;
    end else begin
      adc_power         <= next_adc_power;
      adc_sample        <= next_adc_sample;
      busy              <= next_busy;
      pen_touch_irq_low <= next_irq;
      pen_pullup_en     <= next_pullup;
      x_plus_plate      <= next_plates[3];
      x_minus_plate     <= next_plates[2];
      y_plus_plate      <= next_plates[1];
      y_minus_plate     <= next_plates[0];
      adc_sense_sel     <= next_sense;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion
  // start at sixth fall, one bit per fall up to the 18th
  assign sar_start = sclk_fall & touch_txn &
                     nth(fall_cnt, `TSC_CONV_EDGE);
  assign sar_step  = sclk_fall & touch_txn & (fall_cnt >= `TSC_CONV_EDGE) &
                     (fall_cnt < `TSC_SAR_LAST);

  tsc_sar #(
    .W     (RES_W)
  ) u_sar (
    .clk   (clk),
    .nrst  (nrst),
    .start (sar_start),
    .step  (sar_step),
    .cmp   (cmp_s),
    .trial (adc_dac)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Serial data out
  // MSB at 21st rise, later bits on falls
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sdo    <= 1'h0;
      out_sh <= {RES_W{1'b0}};
    end else if (!cs_act) begin
      sdo    <= 1'h0;
      out_sh <= {RES_W{1'b0}};
    end else if (sclk_rise && touch_txn &&
                 nth(rise_cnt, `TSC_OUT_EDGE)) begin
      sdo    <= adc_dac[RES_W-1];
      out_sh <= {adc_dac[RES_W-2:0], 1'b0};
    end else if (sclk_fall && touch_txn &&
                 (fall_cnt >= `TSC_BUSY_END) &&
                 (fall_cnt < `TSC_XFER_EDGES)) begin
      sdo    <= out_sh[RES_W-1];
      out_sh <= {out_sh[RES_W-2:0], 1'b0};
    end
  end

  // drive only while select is low
  assign sdo_oe  = cs_act;
  assign busy_oe = cs_act;

endmodule // tsc_touch_seq
